/* include/hpi_pkg.sv */
package hpi_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int SEL_W  = 2;
    localparam int CMD_W  = 1 + ADDR_W + DATA_W;
    localparam int PIN_W  = 6;

    // bit positions in the sampled pin bundle
    localparam int PIN_CS   = 0;
    localparam int PIN_DS1  = 1;
    localparam int PIN_DS2  = 2;
    localparam int PIN_RNW  = 3;
    localparam int PIN_HALF = 4;
    localparam int PIN_WIDE = 5;
    localparam logic [PIN_W-1:0] PIN_RST = 6'h07;

    // byte mode register selects
    localparam logic [SEL_W-1:0] SEL_CTRL     = 2'h0;
    localparam logic [SEL_W-1:0] SEL_DATA_INC = 2'h1;
    localparam logic [SEL_W-1:0] SEL_ADDR     = 2'h2;
    localparam logic [SEL_W-1:0] SEL_DATA_FIX = 2'h3;

    localparam logic [DATA_W-1:0] CTRL_RST  = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 18'h0_0001;
    localparam logic              HALF_LOW  = 1'b0;
    localparam logic              HALF_HIGH = 1'b1;

    typedef logic [CMD_W-1:0] hpi_cmd_t;
endpackage : hpi_pkg

/* include/hpi_if.sv */
`timescale 1ns/1ps
interface hpi_if;
    import hpi_pkg::*;
    logic              host_width_select;
    logic              host_chip_select_n;
    logic              host_data_strobe_one_n;
    logic              host_data_strobe_two_n;
    logic              host_read_not_write;
    logic              byte_half_select;
    logic [SEL_W-1:0]  host_register_select;
    logic [ADDR_W-1:0] host_address_bus;
    logic [DATA_W-1:0] host_data_out;
    logic              host_data_oe_n;
    logic [DATA_W-1:0] dev_data_out;
    logic              dev_data_oe_n;
    logic              host_ready_out;
    logic [DATA_W-1:0] host_data_bus;

    // resolved data wire; device drive wins only while its enable is low
    assign host_data_bus = !dev_data_oe_n  ? dev_data_out  :
                           !host_data_oe_n ? host_data_out : '0;

    modport dev (
        input  host_width_select, host_chip_select_n,
        input  host_data_strobe_one_n, host_data_strobe_two_n,
        input  host_read_not_write, byte_half_select,
        input  host_register_select, host_address_bus, host_data_bus,
        output dev_data_out, dev_data_oe_n, host_ready_out
    );
    modport host (
        output host_width_select, host_chip_select_n,
        output host_data_strobe_one_n, host_data_strobe_two_n,
        output host_read_not_write, byte_half_select,
        output host_register_select, host_address_bus,
        output host_data_out, host_data_oe_n,
        input  host_data_bus, host_ready_out
    );
endinterface : hpi_if

/* src/hpi_buf.sv */
`timescale 1ns/1ps
module hpi_buf (
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire hpi_pkg::hpi_cmd_t in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output hpi_pkg::hpi_cmd_t     out_data_o
);
    import hpi_pkg::*;

    hpi_cmd_t   mem_ff [2];
    logic       wr_ptr_ff;
    logic       rd_ptr_ff;
    logic [1:0] cnt_ff;
    logic       push;
    logic       pop;

    assign in_ready_o  = cnt_ff != 2'h2;
    assign out_valid_o = cnt_ff != 2'h0;
    assign out_data_o  = mem_ff[rd_ptr_ff];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff    <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_ff <= !wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= !rd_ptr_ff;
            end
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : hpi_buf

/* src/hpi_dev.sv */
`timescale 1ns/1ps
module hpi_dev (
    input  wire logic                   clock_i,
    input  wire logic                   resetn_i,
    hpi_if.dev                          link,
    output logic                        dma_valid_o,
    input  wire logic                   dma_ready_i,
    output logic                        dma_we_o,
    output logic [hpi_pkg::ADDR_W-1:0]  dma_addr_o,
    output logic [hpi_pkg::DATA_W-1:0]  dma_wdata_o,
    input  wire logic                   dma_rvalid_i,
    input  wire logic [hpi_pkg::DATA_W-1:0] dma_rdata_i,
    input  wire logic                   cpu_req_i,
    input  wire logic [hpi_pkg::ADDR_W-1:0] cpu_addr_i,
    output logic                        cpu_wait_o,
    input  wire logic                   ctrl_wr_i,
    input  wire logic [hpi_pkg::DATA_W-1:0] ctrl_wdata_i,
    output logic [hpi_pkg::DATA_W-1:0]  ctrl_rdata_o
);
    import hpi_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE, ST_ISSUE, ST_RDWAIT, ST_DONE
    } hpi_state_t;

    hpi_state_t        state_ff;
    hpi_state_t        nxt_state;
    logic [PIN_W-1:0]  pin_s1_ff;
    logic [PIN_W-1:0]  pin_s2_ff;
    logic [PIN_W-1:0]  pin_s3_ff;
    logic [PIN_W-1:0]  pin_ff;
    logic              strobe;
    logic              strobe_q_ff;
    logic              start;
    logic              wide;
    logic              rnw;
    logic              half;
    logic [SEL_W-1:0]  sel;
    logic              sel_data;
    logic              need_dma;
    logic              inc_now;
    logic              rd_ff;
    logic              inc_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] data_ff;
    logic [DATA_W-1:0] out_ff;
    logic [DATA_W-1:0] ctrl_ff;
    hpi_cmd_t          cmd_ff;
    logic              push_ready;
    hpi_cmd_t          buf_out;

    function automatic logic [DATA_W-1:0] pick_byte(
        input logic [DATA_W-1:0] word, input logic hi);
        pick_byte = hi ? {{BYTE_W{1'b0}}, word[DATA_W-1:BYTE_W]}
                       : {{BYTE_W{1'b0}}, word[BYTE_W-1:0]};
    endfunction : pick_byte

    function automatic logic [DATA_W-1:0] put_byte(
        input logic [DATA_W-1:0] word, input logic hi,
        input logic [BYTE_W-1:0] b);
        put_byte = hi ? {b, word[BYTE_W-1:0]}
                      : {word[DATA_W-1:BYTE_W], b};
    endfunction : put_byte

    // three stages; a bit changes only once stages two and three agree
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_s1_ff <= PIN_RST;
            pin_s2_ff <= PIN_RST;
            pin_s3_ff <= PIN_RST;
            pin_ff    <= PIN_RST;
        end else begin
            pin_s1_ff <= {link.host_width_select, link.byte_half_select,
                          link.host_read_not_write,
                          link.host_data_strobe_two_n,
                          link.host_data_strobe_one_n,
                          link.host_chip_select_n};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            for (int i = 0; i < PIN_W; i++) begin
                if (pin_s2_ff[i] == pin_s3_ff[i]) begin
                    pin_ff[i] <= pin_s3_ff[i];
                end
            end
        end
    end

    // buses are only looked at once the filtered strobe is seen,
    // relying on the host holding them stable meanwhile
    assign strobe = !pin_ff[PIN_CS]
                 && (!pin_ff[PIN_DS1] || !pin_ff[PIN_DS2]);
    assign start  = strobe && !strobe_q_ff && state_ff == ST_IDLE;
    assign wide   = pin_ff[PIN_WIDE];
    assign rnw    = pin_ff[PIN_RNW];
    assign half   = pin_ff[PIN_HALF];
    assign sel    = link.host_register_select;
    assign sel_data = sel == SEL_DATA_INC || sel == SEL_DATA_FIX;

    // wide: always dma byte: data-register low-half read, high-half write
    always_comb begin
        need_dma = wide || (sel_data && (rnw ? half == HALF_LOW
                                             : half == HALF_HIGH));
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strobe_q_ff <= 1'b0;
        end else begin
            strobe_q_ff <= strobe;
        end
    end

    // no halt input exists here, so emulation stop never blocks it
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (start) begin
                    nxt_state = need_dma ? ST_ISSUE : ST_DONE;
                end
            end
            ST_ISSUE: begin
                if (push_ready) begin
                    nxt_state = rd_ff ? ST_RDWAIT : ST_DONE;
                end
            end
            ST_RDWAIT: begin
                if (dma_rvalid_i) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!strobe) begin
                    nxt_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // access attributes held for the whole access
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_ff  <= 1'b0;
            inc_ff <= 1'b0;
        end else if (start) begin
            rd_ff  <= rnw;
            inc_ff <= !wide && sel == SEL_DATA_INC;
        end
    end

    // wide: full bus loads the address; byte: halves, step on word end
    assign inc_now = (state_ff == ST_ISSUE && push_ready && !rd_ff
                      && inc_ff)
                  || (start && !wide && rnw && sel == SEL_DATA_INC
                      && half == HALF_HIGH);
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_ff <= '0;
        end else if (start && wide) begin
            addr_ff <= link.host_address_bus;
        end else if (start && sel == SEL_ADDR && !rnw) begin
            addr_ff <= {2'h0, put_byte(addr_ff[DATA_W-1:0], half,
                         link.host_data_bus[BYTE_W-1:0])};
        end else if (inc_now) begin
            addr_ff <= addr_ff + ADDR_STEP;
        end
    end

    // data register: pending low half on write, fetched word on read
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            data_ff <= '0;
        end else if (state_ff == ST_RDWAIT && dma_rvalid_i) begin
            data_ff <= dma_rdata_i;
        end else if (start && !wide && sel_data && !rnw
                     && half == HALF_LOW) begin
            data_ff <= put_byte(data_ff, HALF_LOW,
                                link.host_data_bus[BYTE_W-1:0]);
        end
    end

    // dma command formed at start; address taken from bus in wide mode
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_ff <= '0;
        end else if (start && wide) begin
            cmd_ff <= {!rnw, link.host_address_bus,
                       link.host_data_bus};
        end else if (start) begin
            cmd_ff <= {!rnw, addr_ff,
                       put_byte(data_ff, HALF_HIGH,
                                link.host_data_bus[BYTE_W-1:0])};
        end
    end

    // control register: host write wins over processor write
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_ff <= CTRL_RST;
        end else if (start && !wide && sel == SEL_CTRL && !rnw) begin
            ctrl_ff <= put_byte(ctrl_ff, half,
                                link.host_data_bus[BYTE_W-1:0]);
        end else if (ctrl_wr_i) begin
            ctrl_ff <= ctrl_wdata_i;
        end
    end
    assign ctrl_rdata_o = ctrl_ff;

    // read value presented to the host
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_ff <= '0;
        end else if (state_ff == ST_RDWAIT && dma_rvalid_i) begin
            out_ff <= wide ? dma_rdata_i
                           : pick_byte(dma_rdata_i, HALF_LOW);
        end else if (start && !wide) begin
            unique case (sel)
                SEL_CTRL: out_ff <= pick_byte(ctrl_ff, half);
                SEL_ADDR: out_ff <= pick_byte(addr_ff[DATA_W-1:0], half);
                default:  out_ff <= pick_byte(data_ff, half);
            endcase
        end
    end

    // ready stays low until the word is queued or fetched; without dma it rises the cycle after start
    assign link.host_ready_out = state_ff == ST_DONE;
    assign link.dev_data_oe_n  = !(state_ff == ST_DONE && rd_ff);
    assign link.dev_data_out   = out_ff;

    // two entries so a stalled dma port loses no command
    hpi_buf u_buf (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (state_ff == ST_ISSUE),
        .in_ready_o  (push_ready),
        .in_data_i   (cmd_ff),
        .out_valid_o (dma_valid_o),
        .out_ready_i (dma_ready_i),
        .out_data_o  (buf_out)
    );

    assign dma_we_o    = buf_out[CMD_W-1];
    assign dma_addr_o  = buf_out[CMD_W-2:DATA_W];
    assign dma_wdata_o = buf_out[DATA_W-1:0];

    // same-location clash: dma word goes first, processor retries
    assign cpu_wait_o = cpu_req_i && dma_valid_o && dma_ready_i
                     && cpu_addr_i == dma_addr_o;
endmodule : hpi_dev

/* src/hpi_host.sv */
`timescale 1ns/1ps
module hpi_host (
    input  wire logic                       clock_i,
    input  wire logic                       resetn_i,
    hpi_if.host                             link,
    input  wire logic                       wide_mode_i,
    input  wire logic                       cmd_valid_i,
    output logic                            cmd_ready_o,
    input  wire logic                       cmd_write_i,
    input  wire logic [hpi_pkg::SEL_W-1:0]  cmd_sel_i,
    input  wire logic [hpi_pkg::ADDR_W-1:0] cmd_addr_i,
    input  wire logic [hpi_pkg::DATA_W-1:0] cmd_wdata_i,
    output logic                            rsp_valid_o,
    output logic [hpi_pkg::DATA_W-1:0]      rsp_data_o
);
    import hpi_pkg::*;

    typedef enum logic [1:0] {
        HS_IDLE, HS_SETUP, HS_STROBE, HS_RELEASE
    } hpi_hstate_t;

    hpi_hstate_t       state_ff;
    logic [2:0]        rdy_sync_ff;
    logic              rdy_ff;
    logic              write_ff;
    logic              half_ff;
    logic              rsp_ff;
    logic [SEL_W-1:0]  sel_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic              last;

    // ready crosses from the device: three stages, agree rule
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdy_sync_ff <= 3'h0;
            rdy_ff      <= 1'b0;
        end else begin
            rdy_sync_ff <= {rdy_sync_ff[1:0], link.host_ready_out};
            if (rdy_sync_ff[1] == rdy_sync_ff[2]) begin
                rdy_ff <= rdy_sync_ff[2];
            end
        end
    end

    assign last = wide_mode_i || half_ff == HALF_HIGH;

    // strobes stay idle under reset
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= HS_IDLE;
            half_ff  <= HALF_LOW;
            rsp_ff   <= 1'b0;
        end else begin
            rsp_ff <= 1'b0;
            unique case (state_ff)
                HS_IDLE: begin
                    half_ff <= HALF_LOW;
                    if (cmd_valid_i) begin
                        state_ff <= HS_SETUP;
                    end
                end
                HS_SETUP: state_ff <= HS_STROBE;
                HS_STROBE: begin
                    if (rdy_ff) begin
                        state_ff <= HS_RELEASE;
                    end
                end
                HS_RELEASE: begin
                    if (!rdy_ff && last) begin
                        state_ff <= HS_IDLE;
                        rsp_ff   <= 1'b1;
                    end else if (!rdy_ff) begin
                        half_ff  <= HALF_HIGH;
                        state_ff <= HS_SETUP;
                    end
                end
            endcase
        end
    end

    // operation held stable across both halves
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            write_ff <= 1'b0;
            sel_ff   <= SEL_CTRL;
            addr_ff  <= '0;
            wdata_ff <= '0;
        end else if (state_ff == HS_IDLE && cmd_valid_i) begin
            write_ff <= cmd_write_i;
            sel_ff   <= cmd_sel_i;
            addr_ff  <= cmd_addr_i;
            wdata_ff <= cmd_wdata_i;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_ff <= '0;
        end else if (state_ff == HS_STROBE && rdy_ff && !write_ff) begin
            if (wide_mode_i) begin
                rdata_ff <= link.host_data_bus;
            end else if (half_ff == HALF_HIGH) begin
                rdata_ff[DATA_W-1:BYTE_W] <= link.host_data_bus[BYTE_W-1:0];
            end else begin
                rdata_ff[BYTE_W-1:0] <= link.host_data_bus[BYTE_W-1:0];
            end
        end
    end

    assign cmd_ready_o = state_ff == HS_IDLE;
    assign rsp_valid_o = rsp_ff;
    assign rsp_data_o  = rdata_ff;

    assign link.host_width_select      = wide_mode_i;
    assign link.host_chip_select_n     = state_ff != HS_STROBE;
    assign link.host_data_strobe_one_n = state_ff != HS_STROBE;
    assign link.host_data_strobe_two_n = 1'b1;
    assign link.host_read_not_write    = !write_ff;
    assign link.byte_half_select       = half_ff;
    assign link.host_register_select   = sel_ff;
    assign link.host_address_bus       = addr_ff;
    assign link.host_data_out = wide_mode_i ? wdata_ff
        : {{BYTE_W{1'b0}}, half_ff ? wdata_ff[DATA_W-1:BYTE_W]
                                   : wdata_ff[BYTE_W-1:0]};
    assign link.host_data_oe_n = !(write_ff && state_ff != HS_IDLE);
endmodule : hpi_host

/* testbench/hpi_monitor.sv */
`timescale 1ns/1ps
module hpi_monitor (
    input wire logic                       clock_i,
    input wire logic                       resetn_i,
    input wire logic                       host_chip_select_n,
    input wire logic                       host_data_strobe_one_n,
    input wire logic                       host_read_not_write,
    input wire logic [hpi_pkg::ADDR_W-1:0] host_address_bus,
    input wire logic [hpi_pkg::DATA_W-1:0] host_data_out,
    input wire logic                       host_ready_out,
    input wire logic                       dev_data_oe_n
);
    import hpi_pkg::*;
    default clocking mon_cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    strobe_in_cs_a: assert property (
        !host_data_strobe_one_n |-> !host_chip_select_n)
        else $error("strobe seen without chip select");
    bus_hold_a: assert property (
        !host_chip_select_n && !host_ready_out |=> $stable(host_address_bus)
        && $stable(host_read_not_write) && $stable(host_data_out))
        else $error("host bus moved before ready");
    release_ready_a: assert property (
        $rose(host_chip_select_n) |-> host_ready_out)
        else $error("host released before ready");
    start_idle_a: assert property (
        $fell(host_chip_select_n) |-> !host_ready_out)
        else $error("access started while ready still high");
    ready_bound_a: assert property (
        $fell(host_chip_select_n) |-> ##[4:200] host_ready_out)
        else $error("access never completed");
    ready_cause_a: assert property (
        $rose(host_ready_out) |->
        !host_chip_select_n && !host_data_strobe_one_n)
        else $error("ready rose without an access");
    ready_hold_a: assert property (
        host_ready_out && !host_chip_select_n && !host_data_strobe_one_n
        |=> host_ready_out)
        else $error("ready dropped during access");
    read_drive_a: assert property (
        $fell(dev_data_oe_n) |-> host_read_not_write && !host_chip_select_n)
        else $error("device drove data outside a read");
endmodule : hpi_monitor

/* testbench/tb_host_port_interface.sv */
`timescale 1ns/1ps
module tb_host_port_interface;
    import hpi_pkg::*;
    logic              clock_i, resetn_i, wide_mode_i, cmd_valid_i, hit;
    logic              cmd_write_i, cmd_ready_o, rsp_valid_o, dma_valid_o;
    logic              dma_ready_i, dma_we_o, dma_rvalid_i, cpu_req_i;
    logic              cpu_wait_o, ctrl_wr_i, half_exp, prev_cs_n;
    logic [SEL_W-1:0]  cmd_sel_i;
    logic [ADDR_W-1:0] cmd_addr_i, dma_addr_o, cpu_addr_i, hold, a;
    logic [DATA_W-1:0] cmd_wdata_i, rsp_data_o, dma_wdata_o, dma_rdata_i;
    logic [DATA_W-1:0] ctrl_wdata_i, ctrl_rdata_o, ctrl_ref;
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
    logic [ADDR_W-1:0] q [$];
    int                mismatches, num_checks, cycles, rsp_cnt;
    bit                stall;

    hpi_if link ();
    hpi_host i_hpi_host (.*);
    hpi_dev i_hpi_dev (.*);
    hpi_monitor i_hpi_monitor (.clock_i(clock_i), .resetn_i(resetn_i),
        .host_chip_select_n(link.host_chip_select_n),
        .host_data_strobe_one_n(link.host_data_strobe_one_n),
        .host_read_not_write(link.host_read_not_write),
        .host_address_bus(link.host_address_bus),
        .host_data_out(link.host_data_out),
        .host_ready_out(link.host_ready_out),
        .dev_data_oe_n(link.dev_data_oe_n));

    // unwritten words read back a pattern tied to their address
    function automatic logic [DATA_W-1:0] dflt(logic [ADDR_W-1:0] x);
        return x[15:0] ^ 16'h5a5a;
    endfunction : dflt

    function automatic logic [DATA_W-1:0] expect_rd(logic [ADDR_W-1:0] x);
        return ref_mem.exists(x) ? ref_mem[x] : dflt(x);
    endfunction : expect_rd

    task automatic chk(input string what, input logic [DATA_W-1:0] e, g);
        num_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", what, e, g);
            mismatches++;
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    task automatic do_cmd(input logic w, input logic [SEL_W-1:0] s,
        input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] e;
        cpu_addr_i <= wide_mode_i ? ad : hold;
        if (wide_mode_i) begin
            e = expect_rd(ad);
            if (w) ref_mem[ad] = d;
        end else if (s == SEL_ADDR) begin
            e = hold[15:0];
            if (w) hold = {2'b00, d};
        end else if (s == SEL_CTRL) begin
            e = ctrl_ref;
            if (w) ctrl_ref = d;
        end else begin
            e = expect_rd(hold);
            if (w) ref_mem[hold] = d;
            if (s == SEL_DATA_INC) hold = hold + ADDR_STEP;
        end
        cmd_write_i <= w;
        cmd_sel_i   <= s;
        cmd_addr_i  <= ad;
        cmd_wdata_i <= d;
        cmd_valid_i <= 1'b1;
        @(negedge clock_i);
        while (cmd_ready_o !== 1'b1) @(negedge clock_i);
        @(posedge clock_i);
        cmd_valid_i <= 1'b0;
        @(negedge clock_i);
        while (rsp_valid_o !== 1'b1) @(negedge clock_i);
        if (!w) chk("read data", e, rsp_data_o);
        @(posedge clock_i);
    endtask : do_cmd

    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // far memory with random stalls; processor pokes at the same address
    always @(posedge clock_i) begin
        cycles++;
        if (rsp_valid_o === 1'b1) rsp_cnt++;
        dma_rvalid_i <= 1'b0;
        dma_ready_i  <= resetn_i && !stall && $urandom_range(3) != 0;
        cpu_req_i    <= resetn_i && $urandom_range(1) == 1;
        if (dma_valid_o === 1'b1 && dma_ready_i) begin
            if (dma_we_o === 1'b1) mem[dma_addr_o] = dma_wdata_o;
            dma_rvalid_i <= !dma_we_o;
            dma_rdata_i  <= mem.exists(dma_addr_o) ? mem[dma_addr_o]
                                                   : dflt(dma_addr_o);
        end
        if (cycles == 30000) begin
            $display("MISMATCH watchdog expected done seen hang");
            mismatches++;
            end_of_test();
        end
    end

    always @(negedge clock_i) begin
        hit = dma_valid_o === 1'b1 && dma_ready_i && cpu_addr_i === dma_addr_o;
        if (resetn_i && cpu_req_i) chk("cpu wait", 16'(hit), 16'(cpu_wait_o));
        if (!resetn_i) begin
            half_exp = HALF_LOW;
        end else if (prev_cs_n && link.host_chip_select_n === 1'b0
                     && !wide_mode_i) begin
            chk("half", 16'(half_exp), 16'(link.byte_half_select));
            half_exp = !half_exp;
        end
        prev_cs_n = link.host_chip_select_n;
    end

    initial begin
        {resetn_i, cmd_valid_i, cmd_write_i, ctrl_wr_i, stall} = '0;
        {cmd_sel_i, cmd_addr_i, cmd_wdata_i, cpu_addr_i} = '0;
        {ctrl_wdata_i, ctrl_ref, hold} = '0;
        wide_mode_i = 1'b1;
        void'($urandom(32'hc1ac_d7f6));
        repeat (20) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        q = '{18'h0_0000, 18'h3_ffff};
        repeat (10) q.push_back(ADDR_W'($urandom));
        foreach (q[i]) do_cmd(1'b1, SEL_DATA_FIX, q[i], DATA_W'($urandom));
        foreach (q[i]) do_cmd(1'b0, SEL_DATA_FIX, q[i], '0);
        do_cmd(1'b1, SEL_CTRL, 18'h0_0040, 16'h1234);
        chk("ctrl untouched", ctrl_ref, ctrl_rdata_o);
        $display("test wide done");
        // writes pile up in the two-entry buffer while the memory stalls
        stall = 1'b1;
        // clear off the edge, after the last pulse has been counted
        @(negedge clock_i) rsp_cnt = 0;
        @(posedge clock_i);
        q.delete();
        fork
            repeat (3) begin
                a = ADDR_W'($urandom);
                q.push_back(a);
                do_cmd(1'b1, SEL_DATA_FIX, a, DATA_W'($urandom));
            end
            begin
                repeat (120) @(posedge clock_i);
                chk("writes taken", 16'd2, 16'(rsp_cnt));
                stall = 1'b0;
            end
        join
        foreach (q[i]) do_cmd(1'b0, SEL_DATA_FIX, q[i], '0);
        $display("test stall done");
        wide_mode_i <= 1'b0;
        // let the mode settle before the model reads it
        @(posedge clock_i);
        do_cmd(1'b1, SEL_ADDR, '0, 16'h0000);
        do_cmd(1'b0, SEL_DATA_FIX, '0, '0);
        a = ADDR_W'($urandom_range(16'hfff0));
        do_cmd(1'b1, SEL_ADDR, '0, a[15:0]);
        repeat (3) do_cmd(1'b1, SEL_DATA_INC, '0, DATA_W'($urandom));
        do_cmd(1'b0, SEL_ADDR, '0, '0);
        do_cmd(1'b1, SEL_ADDR, '0, a[15:0]);
        repeat (2) do_cmd(1'b0, SEL_DATA_FIX, '0, '0);
        repeat (3) do_cmd(1'b0, SEL_DATA_INC, '0, '0);
        do_cmd(1'b1, SEL_CTRL, '0, 16'h5a0f);
        chk("ctrl host", ctrl_ref, ctrl_rdata_o);
        ctrl_wdata_i <= 16'hc3e1;
        ctrl_wr_i    <= 1'b1;
        @(posedge clock_i);
        ctrl_wr_i    <= 1'b0;
        ctrl_ref = 16'hc3e1;
        do_cmd(1'b0, SEL_CTRL, '0, '0);
        $display("test byte done");
        end_of_test();
    end
endmodule : tb_host_port_interface
